/* File: common/cccr_pkg.sv */
package cccr_pkg;

  // Register map, byte addresses on the APB side
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // Control register field positions
  localparam int unsigned ALIGN8_BIT = 9;
  localparam int unsigned FAULT_IGN_BIT = 8;
  localparam int unsigned DIV0_BIT = 4;
  localparam int unsigned MISALIGN_BIT = 3;
  localparam int unsigned UNPRIV_PEND_BIT = 1;
  localparam int unsigned NONBASE_BIT = 0;

  // Control register reset values, one per field
  localparam logic ALIGN8_RESET = 1'b1;
  localparam logic FAULT_IGN_RESET = 1'b0;
  localparam logic DIV0_RESET = 1'b0;
  localparam logic MISALIGN_RESET = 1'b0;
  localparam logic UNPRIV_PEND_RESET = 1'b0;
  localparam logic NONBASE_RESET = 1'b0;

  // Stack alignment bit may be built read-only
  localparam logic ALIGN8_WRITABLE = 1'b1;

  // Event status register field positions
  localparam int unsigned ST_DIV0_BIT = 0;
  localparam int unsigned ST_MISALIGN_BIT = 1;
  localparam int unsigned ST_LOCKUP_BIT = 2;
  localparam int unsigned ST_TRIG_REFUSE_BIT = 3;
  localparam int unsigned ST_THREAD_FAULT_BIT = 4;
  localparam int unsigned ST_FAULT_IGN_BIT = 5;
  localparam int unsigned ST_WIDTH = 6;
  localparam logic [5:0] STATUS_RESET = 6'h00;

  // Stack frame alignment
  localparam int unsigned SP_ALIGN_BITS = 3;

  typedef struct packed {
    logic exception_frame_align8;
    logic high_priority_fault_ignore;
    logic zero_divide_trap_enable;
    logic misaligned_access_trap_enable;
    logic unprivileged_pend_enable;
    logic non_base_thread_entry_enable;
  } cccr_cfg_t;

  // One-cycle event requests from the core
  typedef struct packed {
    logic div_zero;
    logic unaligned_single;
    logic unaligned_multi;
    logic unaligned_excl;
    logic trig_access;
    logic trig_unpriv;
    logic thread_return;
    logic thread_nonbase;
    logic precise_fault;
    logic fault_prio_neg;
    logic exc_entry;
    logic [31:0] sp;
  } cccr_req_t;

  // Registered decisions back to the core
  typedef struct packed {
    logic div_trap;
    logic align_fault;
    logic trig_grant;
    logic trig_refuse;
    logic thread_grant;
    logic thread_fault;
    logic lockup;
    logic fault_ignored;
    logic entry_valid;
    logic sp_adjusted;
    logic [31:0] entry_sp;
  } cccr_act_t;

endpackage : cccr_pkg

/* File: rtl/cccr_ctl_bit.sv */
`timescale 1ns/100ps
`default_nettype none

module cccr_ctl_bit #(
  parameter logic WRITABLE = 1'b1,
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic wr_val,
  output logic q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_VAL;
    end else if (WRITABLE && wr_en) begin
      q <= wr_val;
    end
  end

endmodule : cccr_ctl_bit

`default_nettype wire

/* File: rtl/cccr_core_config_control.sv */
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module cccr_core_config_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cccr_pkg::cccr_cfg_t cfg,
  input wire cccr_pkg::cccr_req_t req,
  output cccr_pkg::cccr_act_t act
);

  logic access_phase;
  logic wr_commit;
  logic ctl_sel;
  logic status_sel;
  logic ctl_wr_lo;
  logic ctl_wr_hi;
  logic [31:0] rd_word;
  logic [5:0] status_reg;
  logic [5:0] status_next;
  logic [5:0] status_set;
  logic [5:0] status_clr;
  cccr_pkg::cccr_act_t act_next;
  logic [31:0] sp_aligned;

  // Bus decode
  assign access_phase = psel && penable;
  assign ctl_sel = (paddr == cccr_pkg::CTL_OFFSET);
  assign status_sel = (paddr == cccr_pkg::STATUS_OFFSET);

  // Writes land only at the edge where pready is seen high
  assign wr_commit = access_phase && pready && pwrite;

  // Byte lanes: fault-ignore and align live in lane 1, the rest in lane 0
  assign ctl_wr_lo = wr_commit && ctl_sel && pstrb[0];
  assign ctl_wr_hi = wr_commit && ctl_sel && pstrb[1];

  cccr_ctl_bit #(
    .WRITABLE(cccr_pkg::ALIGN8_WRITABLE),
    .RESET_VAL(cccr_pkg::ALIGN8_RESET)
  ) u_align8 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ctl_wr_hi),
    .wr_val(pwdata[cccr_pkg::ALIGN8_BIT]),
    .q(cfg.exception_frame_align8)
  );

  cccr_ctl_bit #(
    .WRITABLE(1'b1),
    .RESET_VAL(cccr_pkg::FAULT_IGN_RESET)
  ) u_fault_ign (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ctl_wr_hi),
    .wr_val(pwdata[cccr_pkg::FAULT_IGN_BIT]),
    .q(cfg.high_priority_fault_ignore)
  );

  cccr_ctl_bit #(
    .WRITABLE(1'b1),
    .RESET_VAL(cccr_pkg::DIV0_RESET)
  ) u_div0 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ctl_wr_lo),
    .wr_val(pwdata[cccr_pkg::DIV0_BIT]),
    .q(cfg.zero_divide_trap_enable)
  );

  cccr_ctl_bit #(
    .WRITABLE(1'b1),
    .RESET_VAL(cccr_pkg::MISALIGN_RESET)
  ) u_misalign (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ctl_wr_lo),
    .wr_val(pwdata[cccr_pkg::MISALIGN_BIT]),
    .q(cfg.misaligned_access_trap_enable)
  );

  cccr_ctl_bit #(
    .WRITABLE(1'b1),
    .RESET_VAL(cccr_pkg::UNPRIV_PEND_RESET)
  ) u_unpriv_pend (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ctl_wr_lo),
    .wr_val(pwdata[cccr_pkg::UNPRIV_PEND_BIT]),
    .q(cfg.unprivileged_pend_enable)
  );

  cccr_ctl_bit #(
    .WRITABLE(1'b1),
    .RESET_VAL(cccr_pkg::NONBASE_RESET)
  ) u_nonbase (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ctl_wr_lo),
    .wr_val(pwdata[cccr_pkg::NONBASE_BIT]),
    .q(cfg.non_base_thread_entry_enable)
  );

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ctl_sel) begin
      rd_word[cccr_pkg::ALIGN8_BIT] = cfg.exception_frame_align8;
      rd_word[cccr_pkg::FAULT_IGN_BIT] = cfg.high_priority_fault_ignore;
      rd_word[cccr_pkg::DIV0_BIT] = cfg.zero_divide_trap_enable;
      rd_word[cccr_pkg::MISALIGN_BIT] = cfg.misaligned_access_trap_enable;
      rd_word[cccr_pkg::UNPRIV_PEND_BIT] = cfg.unprivileged_pend_enable;
      rd_word[cccr_pkg::NONBASE_BIT] = cfg.non_base_thread_entry_enable;
    end else if (status_sel) begin
      rd_word[cccr_pkg::ST_WIDTH-1:0] = status_reg;
    end
  end

  // One wait state keeps pready and prdata straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access_phase && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access_phase && !pready && !pwrite) begin
      prdata <= rd_word;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // Unmapped addresses answer with an error, nothing stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access_phase && !pready && !ctl_sel && !status_sel;
    end
  end

  // Stack pointer rounded down to the next 8-byte boundary
  assign sp_aligned = {req.sp[31:cccr_pkg::SP_ALIGN_BITS],
                       {cccr_pkg::SP_ALIGN_BITS{1'b0}}};

  // Decisions from the current controls
  always_comb begin
    act_next = '0;
    act_next.div_trap = req.div_zero && cfg.zero_divide_trap_enable;
    act_next.align_fault =
      (req.unaligned_single && cfg.misaligned_access_trap_enable) ||
      req.unaligned_multi || req.unaligned_excl;
    act_next.trig_grant = req.trig_access &&
      (!req.trig_unpriv || cfg.unprivileged_pend_enable);
    act_next.trig_refuse = req.trig_access && req.trig_unpriv &&
      !cfg.unprivileged_pend_enable;
    act_next.thread_fault = req.thread_return && req.thread_nonbase &&
      !cfg.non_base_thread_entry_enable;
    act_next.thread_grant = req.thread_return &&
      (!req.thread_nonbase || cfg.non_base_thread_entry_enable);
    act_next.lockup = req.precise_fault && req.fault_prio_neg &&
      !cfg.high_priority_fault_ignore;
    act_next.fault_ignored = req.precise_fault && req.fault_prio_neg &&
      cfg.high_priority_fault_ignore;
    act_next.entry_valid = req.exc_entry;
    if (req.exc_entry) begin
      if (cfg.exception_frame_align8) begin
        act_next.entry_sp = sp_aligned;
        act_next.sp_adjusted = (sp_aligned != req.sp);
      end else begin
        act_next.entry_sp = req.sp;
        act_next.sp_adjusted = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= '0;
    end else begin
      act <= act_next;
    end
  end

  // Sticky event record, write one to clear
  always_comb begin
    status_set = '0;
    status_set[cccr_pkg::ST_DIV0_BIT] = act_next.div_trap;
    status_set[cccr_pkg::ST_MISALIGN_BIT] = act_next.align_fault;
    status_set[cccr_pkg::ST_LOCKUP_BIT] = act_next.lockup;
    status_set[cccr_pkg::ST_TRIG_REFUSE_BIT] = act_next.trig_refuse;
    status_set[cccr_pkg::ST_THREAD_FAULT_BIT] = act_next.thread_fault;
    status_set[cccr_pkg::ST_FAULT_IGN_BIT] = act_next.fault_ignored;
  end

  assign status_clr = (wr_commit && status_sel && pstrb[0]) ?
                      pwdata[cccr_pkg::ST_WIDTH-1:0] : 6'h00;

  // Set wins over a clear in the same cycle
  assign status_next = (status_reg & ~status_clr) | status_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= cccr_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

endmodule : cccr_core_config_control

`default_nettype wire

/* File: test/cccr_core_config_control_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module cccr_core_config_control_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire cccr_pkg::cccr_cfg_t cfg,
  input wire cccr_pkg::cccr_req_t req,
  input wire cccr_pkg::cccr_act_t act
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rst; $rose(presetn) |-> cfg.exception_frame_align8; endproperty
  a_rst: assert property (p_rst) else $error("align reset");
  property p_div; req.div_zero |=>
    act.div_trap == $past(cfg.zero_divide_trap_enable); endproperty
  a_div: assert property (p_div) else $error("div trap");
  property p_mis; req.unaligned_single && cfg.misaligned_access_trap_enable
    |=> act.align_fault; endproperty
  a_mis: assert property (p_mis) else $error("misalign trap");
  property p_mul; req.unaligned_multi || req.unaligned_excl
    |=> act.align_fault; endproperty
  a_mul: assert property (p_mul) else $error("multi fault");
  property p_trig; req.trig_access && req.trig_unpriv |=>
    act.trig_refuse != $past(cfg.unprivileged_pend_enable)
    && act.trig_grant == $past(cfg.unprivileged_pend_enable); endproperty
  a_trig: assert property (p_trig) else $error("trigger access");
  property p_thf; req.thread_return && req.thread_nonbase
    && !cfg.non_base_thread_entry_enable |=> act.thread_fault
    && !act.thread_grant; endproperty
  a_thf: assert property (p_thf) else $error("thread fault");
  property p_thg; req.thread_return && cfg.non_base_thread_entry_enable
    |=> act.thread_grant && !act.thread_fault; endproperty
  a_thg: assert property (p_thg) else $error("thread grant");
  property p_ign; req.precise_fault && req.fault_prio_neg |=>
    act.fault_ignored == $past(cfg.high_priority_fault_ignore)
    && act.lockup != act.fault_ignored; endproperty
  a_ign: assert property (p_ign) else $error("fault ignore");
  property p_sp; req.exc_entry |=> act.entry_sp ==
    ($past(cfg.exception_frame_align8) ? $past(req.sp) & 32'hffff_fff8
    : $past(req.sp)); endproperty
  a_sp: assert property (p_sp) else $error("entry sp");
  property p_rsv; pready && !pwrite && paddr == cccr_pkg::CTL_OFFSET |->
    prdata[31:10] == 22'h0 && prdata[7:5] == 3'h0 && !prdata[2]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  c_div: cover property (act.div_trap);
  c_adj: cover property (act.sp_adjusted);
  c_lock: cover property (act.lockup);
endmodule : cccr_core_config_control_checker

bind cccr_core_config_control cccr_core_config_control_checker i_chk (
  .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .cfg(cfg), .req(req), .act(act));

`default_nettype wire

/* File: test/tb_core_config_control_register.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_core_config_control_register;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, s, b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pstrb;
  cccr_pkg::cccr_cfg_t cfg;
  cccr_pkg::cccr_req_t req;
  cccr_pkg::cccr_act_t act;
  int err_count, tests_run;
  localparam logic [11:0] CTL = cccr_pkg::CTL_OFFSET;
  localparam logic [11:0] STA = cccr_pkg::STATUS_OFFSET;

  cccr_core_config_control i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
    .req(req), .act(act));

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // Values seen here are those sampled at the answering edge
    d = prdata;
    s = pslverr;
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(64'(d), 64'(x));
  endtask : rd

  // Pulse one request, then look at the registered answer
  task automatic run(input cccr_pkg::cccr_req_t r,
                     input cccr_pkg::cccr_act_t x);
    req <= r;
    @(posedge pclk);
    req <= '0;
    @(posedge pclk);
    chk(64'(act), 64'(x));
  endtask : run

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, req} = '0;
    pstrb = 4'hf;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, 32'h0000_0200);
    rd(STA, 32'h0);
    apb(1'b1, CTL, 32'hffff_ffff);
    rd(CTL, 32'h0000_031b);
    apb(1'b0, 12'h008, 32'h0);
    chk(64'({s, d}), 64'h1_0000_0000);
    for (int e = 0; e < 2; e++) begin
      b = e[0];
      apb(1'b1, CTL, b ? 32'h31b : 32'h0);
      chk(64'(cfg), b ? 64'h3f : 64'h0);
      run('{div_zero: 1'b1, default: '0}, '{div_trap: b, default: '0});
      run('{unaligned_single: 1'b1, default: '0},
          '{align_fault: b, default: '0});
      run('{unaligned_multi: 1'b1, default: '0},
          '{align_fault: 1'b1, default: '0});
      run('{unaligned_excl: 1'b1, default: '0},
          '{align_fault: 1'b1, default: '0});
      run('{trig_access: 1'b1, trig_unpriv: 1'b1, default: '0},
          '{trig_grant: b, trig_refuse: !b, default: '0});
      run('{thread_return: 1'b1, thread_nonbase: 1'b1, default: '0},
          '{thread_grant: b, thread_fault: !b, default: '0});
      run('{precise_fault: 1'b1, fault_prio_neg: 1'b1, default: '0},
          '{lockup: !b, fault_ignored: b, default: '0});
      run('{exc_entry: 1'b1, sp: 32'h2000_000c, default: '0},
          '{entry_valid: 1'b1, sp_adjusted: b,
            entry_sp: b ? 32'h2000_0008 : 32'h2000_000c, default: '0});
      rd(STA, b ? 32'h23 : 32'h1e);
      apb(1'b1, STA, 32'h3f);
      rd(STA, 32'h0);
    end
    // Lane 1 only: align and fault-ignore cleared, lane 0 kept
    pstrb <= 4'h2;
    apb(1'b1, CTL, 32'h0);
    chk(64'(cfg), 64'h0f);
    pstrb <= 4'hf;
    end_of_test();
  end
endmodule : tb_core_config_control_register

`default_nettype wire
